// >>> dv/host_axi_model.sv
module host_axi_model (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic slow_i, // Stall on alternate cycles.
  input wire logic arvalid_i, // Read address valid.
  output logic arready_o, // Read address ready.
  input wire logic [31:0] araddr_i, // Read address.
  output logic rvalid_o, // Read data valid.
  input wire logic rready_i, // Read data ready.
  output logic [31:0] rdata_o, // Read data.
  output logic rlast_o, // Last read beat.
  input wire logic awvalid_i, // Write address valid.
  output logic awready_o, // Write address ready.
  input wire logic wvalid_i, // Write data valid.
  output logic wready_o, // Write data ready.
  input wire logic [31:0] wdata_i, // Write data.
  input wire logic wlast_i, // Last write beat.
  output logic bvalid_o, // Write response valid.
  input wire logic bready_i, // Write response ready.
  input wire logic sram_req_i, // Memory request.
  output logic sram_ack_o, // Memory done.
  input wire logic [31:0] sram_addr_i, // Memory address.
  output logic [31:0] sram_rdata_o // Memory read data.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] raddr, last;
  logic [31:0] wmem [8];
  logic [3:0] rleft;
  logic ph, wbusy;
  int wn;
  // Idle data lines show the inverse of the last beat, never a stale copy.
  assign arready_o = (rleft == 4'h0) && !(slow_i && ph);
  // Read data valid never drops before its beat is taken.
  assign rvalid_o = (rleft != 4'h0);
  assign rdata_o = rvalid_o ? (raddr ^ 32'h5a5a_0000) : ~last;
  assign rlast_o = rvalid_o && (rleft == 4'h1);
  assign awready_o = !wbusy && !(slow_i && ph);
  assign wready_o = wbusy && !bvalid_o && !(slow_i && ph);
  assign sram_rdata_o = sram_ack_o ? ~sram_addr_i : sram_addr_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      rleft <= 4'h0;
      wbusy <= 1'b0;
      bvalid_o <= 1'b0;
      sram_ack_o <= 1'b0;
      ph <= 1'b0;
      last <= 32'h0;
      wn <= 0;
    end else begin
      ph <= ~ph;
      if (arvalid_i && arready_o) begin
        raddr <= araddr_i;
        rleft <= 4'h8;
      end
      if (rvalid_o && rready_i) begin
        raddr <= raddr + 32'h4;
        rleft <= rleft - 4'h1;
        last <= rdata_o;
      end
      if (awvalid_i && awready_o) begin
        wbusy <= 1'b1;
        wn <= 0;
      end
      if (wvalid_i && wready_o) begin
        wmem[wn[2:0]] <= wdata_i;
        wn <= wn + 1;
        bvalid_o <= wlast_i;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        wbusy <= 1'b0;
      end
      sram_ack_o <= sram_req_i && !sram_ack_o;
    end
  end
endmodule

// >>> dv/tb.sv
module tb;
  import bridge_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK_I = 0, RST_I = 1, HWRITE_I = 0, HREADY_O, ARVALID_O, ARREADY_I, RVALID_I, RREADY_O;
  logic RLAST_I, AWVALID_O, AWREADY_I, WVALID_O, WREADY_I, WLAST_O, BVALID_I, BREADY_O;
  logic IN_VALID_I = 0, IN_BAR_I = 0, IN_WRITE_I = 0, IN_READY_O, IN_RVALID_O, SRAM_REQ_O;
  logic SRAM_WE_O, SRAM_ACK_I, BTN_I = 0, HOST_IRQ_O, DMA_START_I = 0, DMA_DONE_O, slow = 0;
  logic [1:0] HTRANS_I = 2'h0, RD_BURST_I = BURST_WRAP, ARBURST_O, AWBURST_O, CFG_GEN_O;
  logic [2:0] ARSIZE_O, AWSIZE_O, CFG_LANES_O;
  logic [3:0] WSTRB_O, CFG_BAR_TYPE_O, DIP_I = 4'h9;
  logic [7:0] ARLEN_O, AWLEN_O, LED_O, CFG_CLK_MHZ_O;
  logic [15:0] IN_OFFSET_I = 16'h0;
  logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, ARADDR_O, RDATA_I, AWADDR_O, WDATA_O;
  logic [31:0] HOST_BASE_I = 32'h8010_0000, IN_WDATA_I = 32'h0, IN_RDATA_O, SRAM_ADDR_O;
  logic [31:0] SRAM_WDATA_O, SRAM_RDATA_I, XFER_LEN_I = 32'h0, CYCLES_O, rd;
  logic [31:0] ar_cap [4], aw_cap [4], sram_cap [3];
  int err_count = 0, num_checks = 0, irq_n = 0, done_n = 0, ar_n = 0, cyc = 0, done_cyc = 0;

  pcie_dma_fabric_bridge dut (.MCLK_I, .RST_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I,
    .HREADY_O, .HRDATA_O, .RD_BURST_I, .HOST_BASE_I, .ARVALID_O, .ARREADY_I, .ARADDR_O,
    .ARLEN_O, .ARSIZE_O, .ARBURST_O, .RVALID_I, .RREADY_O, .RDATA_I, .RLAST_I, .AWVALID_O,
    .AWREADY_I, .AWADDR_O, .AWLEN_O, .AWSIZE_O, .AWBURST_O, .WVALID_O, .WREADY_I, .WDATA_O,
    .WSTRB_O, .WLAST_O, .BVALID_I, .BREADY_O, .IN_VALID_I, .IN_BAR_I, .IN_WRITE_I,
    .IN_OFFSET_I, .IN_WDATA_I, .IN_READY_O, .IN_RVALID_O, .IN_RDATA_O, .SRAM_REQ_O,
    .SRAM_WE_O, .SRAM_ADDR_O, .SRAM_WDATA_O, .SRAM_ACK_I, .SRAM_RDATA_I, .LED_O, .DIP_I,
    .BTN_I, .HOST_IRQ_O, .DMA_START_I, .XFER_LEN_I, .DMA_DONE_O, .CYCLES_O, .CFG_BAR_TYPE_O,
    .CFG_LANES_O, .CFG_GEN_O, .CFG_CLK_MHZ_O);

  host_axi_model pm (.clk_i(MCLK_I), .rst_i(RST_I), .slow_i(slow), .arvalid_i(ARVALID_O),
    .arready_o(ARREADY_I), .araddr_i(ARADDR_O), .rvalid_o(RVALID_I), .rready_i(RREADY_O),
    .rdata_o(RDATA_I), .rlast_o(RLAST_I), .awvalid_i(AWVALID_O), .awready_o(AWREADY_I),
    .wvalid_i(WVALID_O), .wready_o(WREADY_I), .wdata_i(WDATA_O), .wlast_i(WLAST_O),
    .bvalid_o(BVALID_I), .bready_i(BREADY_O), .sram_req_i(SRAM_REQ_O), .sram_ack_o(SRAM_ACK_I),
    .sram_addr_i(SRAM_ADDR_O), .sram_rdata_o(SRAM_RDATA_I));

  always #25 MCLK_I = ~MCLK_I;

  always @(posedge MCLK_I) begin
    cyc <= DMA_START_I ? 0 : cyc + 1;
    if (HOST_IRQ_O === 1'b1) irq_n <= irq_n + 1;
    if (DMA_DONE_O === 1'b1) done_n <= done_n + 1;
    if (DMA_DONE_O === 1'b1) done_cyc <= cyc;
    if (ARVALID_O && ARREADY_I) ar_n <= ar_n + 1;
    if (ARVALID_O && ARREADY_I) ar_cap <= '{ARADDR_O, 32'(ARLEN_O), 32'(ARSIZE_O), 32'(ARBURST_O)};
    if (AWVALID_O && AWREADY_I) aw_cap <= '{AWADDR_O, 32'(AWLEN_O), 32'(AWSIZE_O), 32'(AWBURST_O)};
    if (SRAM_REQ_O && SRAM_ACK_I) sram_cap <= '{SRAM_ADDR_O, 32'(SRAM_WE_O), SRAM_WDATA_O};
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bound(input int n);
    if (n >= 300) begin
      chk("wait_bound", 32'h0, 32'h1);
      final_report;
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] r);
    int n = 0;
    HADDR_I <= a;
    HTRANS_I <= 2'h2;
    HWRITE_I <= w;
    do begin @(posedge MCLK_I); n++; end while (HREADY_O !== 1'b1 && n < 300);
    bound(n);
    HTRANS_I <= 2'h0;
    HWDATA_I <= wd;
    n = 0;
    do begin @(posedge MCLK_I); n++; end while (HREADY_O !== 1'b1 && n < 300);
    bound(n);
    r = HRDATA_O;
  endtask

  task automatic inb(input logic bar, input logic w, input logic [15:0] off,
                     input logic [31:0] wd, output logic [31:0] r);
    int n = 0;
    IN_VALID_I <= 1'b1;
    IN_BAR_I <= bar;
    IN_WRITE_I <= w;
    IN_OFFSET_I <= off;
    IN_WDATA_I <= wd;
    do begin @(posedge MCLK_I); n++; end while (IN_READY_O !== 1'b1 && n < 300);
    IN_VALID_I <= 1'b0;
    do begin @(posedge MCLK_I); n++; end while (IN_RVALID_O !== 1'b1 && n < 300);
    bound(n);
    r = IN_RDATA_O;
  endtask

  task automatic t_cfg;
    chk("bar_type", 32'h0, 32'(CFG_BAR_TYPE_O));
    chk("lanes", 32'h4, 32'(CFG_LANES_O));
    chk("gen", 32'h2, 32'(CFG_GEN_O));
    chk("clk_mhz", 32'd166, 32'(CFG_CLK_MHZ_O));
    $display("test cfg done");
  endtask

  task automatic t_gpio;
    inb(1'b0, 1'b1, GPIO_OUT_OFF, 32'h0000_00a5, rd);
    chk("led_pins", 32'h0000_00a5, 32'(LED_O));
    inb(1'b0, 1'b0, GPIO_OUT_OFF, 32'h0, rd);
    chk("led_read", 32'h0000_00a5, {24'h0, rd[7:0]});
    inb(1'b0, 1'b0, GPIO_IN_OFF, 32'h0, rd);
    chk("dip_read", 32'h9, {28'h0, rd[3:0]});
    DIP_I <= 4'h6;
    repeat (4) @(posedge MCLK_I);
    inb(1'b0, 1'b0, GPIO_IN_OFF, 32'h0, rd);
    chk("dip_read", 32'h6, {28'h0, rd[3:0]});
    $display("test gpio done");
  endtask

  task automatic t_region1;
    inb(1'b1, 1'b0, SCRATCH_OFF, 32'h0, rd);
    chk("scratch_reset", 32'h0, rd);
    inb(1'b1, 1'b1, SCRATCH_OFF, 32'hdead_beef, rd);
    inb(1'b1, 1'b0, SCRATCH_OFF, 32'h0, rd);
    chk("scratch_read", 32'hdead_beef, rd);
    inb(1'b1, 1'b1, 16'h0100, 32'h1234_5678, rd);
    chk("sram_addr", 32'h2000_0100, sram_cap[0]);
    chk("sram_we", 32'h1, sram_cap[1]);
    chk("sram_wdata", 32'h1234_5678, sram_cap[2]);
    inb(1'b1, 1'b0, 16'h0100, 32'h0, rd);
    chk("sram_rd_we", 32'h0, sram_cap[1]);
    chk("sram_rdata", ~32'h2000_0100, rd);
    $display("test region1 done");
  endtask

  task automatic t_irq;
    repeat (2) begin
      BTN_I <= 1'b1;
      repeat (8) @(posedge MCLK_I);
      BTN_I <= 1'b0;
      repeat (8) @(posedge MCLK_I);
    end
    chk("irq_count", 32'h2, 32'(irq_n));
    $display("test irq done");
  endtask

  task automatic t_dma;
    logic [31:0] a = 32'h0003_0040, b = 32'h0004_0020, h;
    int n = 0;
    XFER_LEN_I <= 32'h40;
    DMA_START_I <= 1'b1;
    @(posedge MCLK_I);
    DMA_START_I <= 1'b0;
    slow <= 1'b1;
    h = {HOST_BASE_I[31:20], a[19:0]};
    for (int i = 0; i < 8; i++) begin
      ahb(a + 32'(4 * ((i + 5) % 8)), 1'b0, 32'h0, rd);
      chk("read_word", (h + 32'(4 * ((i + 5) % 8))) ^ 32'h5a5a_0000, rd);
    end
    chk("ar_count", 32'h1, 32'(ar_n));
    chk("ar_addr", h, ar_cap[0]);
    chk("ar_len", 32'h7, ar_cap[1]);
    chk("ar_size", 32'h2, ar_cap[2]);
    chk("ar_burst", 32'(BURST_INCR), ar_cap[3]);
    chk("done_early", 32'h0, 32'(done_n));
    h = {HOST_BASE_I[31:20], b[19:0]};
    for (int i = 0; i < 8; i++) ahb(b + 32'(4 * i), 1'b1, 32'hc0de_0000 + 32'(i), rd);
    while (!(pm.wn == 8 && pm.wbusy === 1'b0 && done_n == 1) && n < 300) begin
      @(posedge MCLK_I);
      n++;
    end
    bound(n);
    chk("aw_addr", h, aw_cap[0]);
    chk("aw_len", 32'h7, aw_cap[1]);
    chk("aw_size", 32'h2, aw_cap[2]);
    chk("aw_burst", 32'(BURST_INCR), aw_cap[3]);
    chk("wstrb", 32'hf, 32'(WSTRB_O));
    for (int i = 0; i < 8; i++) chk("write_word", 32'hc0de_0000 + 32'(i), pm.wmem[i]);
    chk("done_count", 32'h1, 32'(done_n));
    chk("cycles_near", 32'h1, 32'(CYCLES_O + 2 >= done_cyc && CYCLES_O <= done_cyc + 2));
    rd = CYCLES_O;
    repeat (5) @(posedge MCLK_I);
    chk("cycles_hold", rd, CYCLES_O);
    $display("test dma done");
  endtask

  initial begin
    repeat (16) @(posedge MCLK_I);
    RST_I <= 1'b0;
    @(posedge MCLK_I);
    t_cfg;
    t_gpio;
    t_region1;
    t_irq;
    t_dma;
    final_report;
  end
endmodule

// >>> logic/bridge_pkg.sv
// Notes on behaviour
// - Wrap read bursts become incrementing bursts.
// - Writes and wrap or incrementing reads reach the core as incrementing bursts; other read burst types pass unchanged.
// - DMA read misses fetch one 32-byte burst.
// - Returned data fills buffer, completes DMA read.
// - DMA write data collects in 32-byte buffer.
// - Full write buffer issues one 32-byte burst.
// - Transfer runs until programmed length moved.
// - Window zero maps onto general-purpose I/O.
// - Window one maps onto embedded SRAM.
// - Outbound window maps local to host addresses.
// - Both regions are 32-bit memory space.
// - Lines 0-7 drive LEDs, 8-11 read switches.
// - Interface and processor clocks are 166 MHz.
// - Link is revision 2.0, four lanes, Gen2.
// - Timer counts cycles from start to completion.
// - Each button press sends one host interrupt.
// - Host can write and read scratchpad.
// - Scratchpad is 32 bits, in region one.
package bridge_pkg;
  localparam int DW = 32;
  localparam int AW = 32;
  localparam int OFF_W = 16;
  localparam int BEATS = 8;
  localparam int IDX_W = 3;
  localparam int ALIGN_BITS = 5;
  localparam int LINE_BYTES = 32;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [7:0] LEN_LINE = 8'h07;
  localparam logic [3:0] STRB_ALL = 4'hf;
  localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
  localparam logic [BEATS-1:0] MASK_FULL = 8'hff;
  localparam int OUT_WIN_BITS = 20;
  localparam logic [AW-1:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [OFF_W-1:0] GPIO_OUT_OFF = 16'h0000;
  localparam logic [OFF_W-1:0] GPIO_IN_OFF = 16'h0004;
  localparam logic [OFF_W-1:0] SCRATCH_OFF = 16'hfffc;
  localparam logic WIN0_EN = 1'b1;
  localparam logic WIN1_EN = 1'b1;
  localparam logic OUT_WIN0_EN = 1'b1;
  localparam int LED_W = 8;
  localparam int DIP_W = 4;
  localparam logic [DW-1:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [3:0] BAR_MEM32 = 4'h0;
  localparam logic [2:0] LINK_LANES = 3'h4;
  localparam logic [1:0] LINK_GEN2 = 2'h2;
  localparam logic [7:0] CORE_CLK_MHZ = 8'ha6;
  localparam logic [AW-1:0] BYTES_PER_BURST = 32'h0000_0020;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RA = 3'b001,
    S_RD = 3'b010,
    S_WA = 3'b011,
    S_WD = 3'b100,
    S_WB = 3'b101
  } bst_t;
endpackage

// >>> logic/pcie_dma_fabric_bridge.sv
module pcie_dma_fabric_bridge (
  input wire logic MCLK_I, // Clock.
  input wire logic RST_I, // Synchronous reset, high.
  input wire logic [bridge_pkg::AW-1:0] HADDR_I, // DMA address.
  input wire logic [1:0] HTRANS_I, // DMA transfer type.
  input wire logic HWRITE_I, // DMA write.
  input wire logic [bridge_pkg::DW-1:0] HWDATA_I, // DMA write data.
  output logic HREADY_O, // Data phase done.
  output logic [bridge_pkg::DW-1:0] HRDATA_O, // DMA read data.
  input wire logic [1:0] RD_BURST_I, // Read burst type of fabric port.
  input wire logic [bridge_pkg::AW-1:0] HOST_BASE_I, // Host window base.
  output logic ARVALID_O, // Read address valid.
  input wire logic ARREADY_I, // Read address ready.
  output logic [bridge_pkg::AW-1:0] ARADDR_O, // Read address.
  output logic [7:0] ARLEN_O, // Read length.
  output logic [2:0] ARSIZE_O, // Read size.
  output logic [1:0] ARBURST_O, // Read burst type.
  input wire logic RVALID_I, // Read data valid.
  output logic RREADY_O, // Read data ready.
  input wire logic [bridge_pkg::DW-1:0] RDATA_I, // Read data.
  input wire logic RLAST_I, // Last read beat.
  output logic AWVALID_O, // Write address valid.
  input wire logic AWREADY_I, // Write address ready.
  output logic [bridge_pkg::AW-1:0] AWADDR_O, // Write address.
  output logic [7:0] AWLEN_O, // Write length.
  output logic [2:0] AWSIZE_O, // Write size.
  output logic [1:0] AWBURST_O, // Write burst type.
  output logic WVALID_O, // Write data valid.
  input wire logic WREADY_I, // Write data ready.
  output logic [bridge_pkg::DW-1:0] WDATA_O, // Write data.
  output logic [3:0] WSTRB_O, // Write strobes.
  output logic WLAST_O, // Last write beat.
  input wire logic BVALID_I, // Write response valid.
  output logic BREADY_O, // Write response ready.
  input wire logic IN_VALID_I, // Inbound access.
  input wire logic IN_BAR_I, // Region: 0 I/O, 1 SRAM.
  input wire logic IN_WRITE_I, // Inbound write.
  input wire logic [bridge_pkg::OFF_W-1:0] IN_OFFSET_I, // Region offset.
  input wire logic [bridge_pkg::DW-1:0] IN_WDATA_I, // Inbound data.
  output logic IN_READY_O, // Inbound access taken.
  output logic IN_RVALID_O, // Inbound done.
  output logic [bridge_pkg::DW-1:0] IN_RDATA_O, // Inbound read data.
  output logic SRAM_REQ_O, // SRAM access.
  output logic SRAM_WE_O, // SRAM write.
  output logic [bridge_pkg::AW-1:0] SRAM_ADDR_O, // SRAM address.
  output logic [bridge_pkg::DW-1:0] SRAM_WDATA_O, // SRAM write data.
  input wire logic SRAM_ACK_I, // SRAM done.
  input wire logic [bridge_pkg::DW-1:0] SRAM_RDATA_I, // SRAM read data.
  output logic [bridge_pkg::LED_W-1:0] LED_O, // LED lines.
  input wire logic [bridge_pkg::DIP_W-1:0] DIP_I, // Switch lines.
  input wire logic BTN_I, // Push button, high when pressed.
  output logic HOST_IRQ_O, // Interrupt pulse to host.
  input wire logic DMA_START_I, // Start pulse.
  input wire logic [bridge_pkg::AW-1:0] XFER_LEN_I, // Transfer bytes.
  output logic DMA_DONE_O, // Done pulse.
  output logic [bridge_pkg::AW-1:0] CYCLES_O, // Cycle count.
  output logic [3:0] CFG_BAR_TYPE_O, // Region type.
  output logic [2:0] CFG_LANES_O, // Lane count.
  output logic [1:0] CFG_GEN_O, // Link rate.
  output logic [7:0] CFG_CLK_MHZ_O // Core clock rate.
);
  import bridge_pkg::*;

  bst_t st_q;
  logic [AW-1:0] a_addr_q;
  logic a_write_q;
  logic a_pend_q;
  logic [DW-1:0] rbuf_q [BEATS];
  logic [AW-1:ALIGN_BITS] rtag_q;
  logic rvalid_q;
  logic [DW-1:0] wbuf_q [BEATS];
  logic [BEATS-1:0] wmask_q;
  logic [AW-1:ALIGN_BITS] wtag_q;
  logic [IDX_W-1:0] beat_q;
  logic hit;
  logic rd_stall;
  logic [AW-1:0] cv_addr;
  logic [1:0] cv_burst;
  logic [7:0] cv_len;
  logic [2:0] cv_size;
  logic cv_mis;
  logic sk_valid;
  logic sk_ready;
  logic [DW:0] sk_data;
  logic ah_take;

  wrap_to_incr u_conv (
    .addr_i(a_addr_q),
    .burst_i(RD_BURST_I),
    .len_i(LEN_LINE),
    .size_i(SIZE_WORD),
    .addr_o(cv_addr),
    .burst_o(cv_burst),
    .len_o(cv_len),
    .size_o(cv_size),
    .misalign_o(cv_mis)
  );

  skid_buf2 #(.W(DW + 1)) u_rbuf (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .in_valid_i(RVALID_I),
    .in_ready_o(RREADY_O),
    .in_data_i({RLAST_I, RDATA_I}),
    .out_valid_o(sk_valid),
    .out_ready_i(sk_ready),
    .out_data_o(sk_data)
  );

  // The line buffer drains the skid entries only while a fetch is open.
  assign sk_ready = (st_q == S_RD);
  assign hit = rvalid_q && (rtag_q == a_addr_q[AW-1:ALIGN_BITS]);
  assign rd_stall = a_pend_q && !a_write_q && !hit;
  assign HREADY_O = (st_q == S_IDLE) && !rd_stall;
  assign HRDATA_O = rbuf_q[a_addr_q[ALIGN_BITS-1:2]];
  assign ah_take = HTRANS_I[1] && HREADY_O;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      a_pend_q <= 1'b0;
      a_write_q <= 1'b0;
      a_addr_q <= '0;
    end else if (HREADY_O) begin
      a_pend_q <= HTRANS_I[1];
      a_write_q <= HWRITE_I;
      a_addr_q <= HADDR_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_q <= S_IDLE;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (rd_stall) begin
            st_q <= S_RA;
          end else if (a_pend_q && a_write_q &&
                       ((wmask_q | (8'h01 << a_addr_q[ALIGN_BITS-1:2])) == MASK_FULL)) begin
            st_q <= S_WA;
          end
        end
        S_RA: if (ARREADY_I) st_q <= S_RD;
        S_RD: if (sk_valid && sk_data[DW]) st_q <= S_IDLE;
        S_WA: if (AWREADY_I) st_q <= S_WD;
        S_WD: if (WREADY_I && beat_q == LAST_IDX) st_q <= S_WB;
        S_WB: if (BVALID_I) st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      beat_q <= '0;
    end else if ((st_q == S_RD && sk_valid) || (st_q == S_WD && WREADY_I)) begin
      beat_q <= beat_q + 3'h1;
    end else if (st_q == S_IDLE) begin
      beat_q <= '0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (st_q == S_RD && sk_valid) begin
      rbuf_q[beat_q] <= sk_data[DW-1:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rvalid_q <= 1'b0;
      rtag_q <= '0;
    end else if (st_q == S_RA) begin
      rvalid_q <= 1'b0;
      rtag_q <= a_addr_q[AW-1:ALIGN_BITS];
    end else if (st_q == S_RD && sk_valid && sk_data[DW]) begin
      rvalid_q <= 1'b1;
    end else if (st_q == S_IDLE && a_pend_q && a_write_q) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (st_q == S_IDLE && a_pend_q && a_write_q) begin
      wbuf_q[a_addr_q[ALIGN_BITS-1:2]] <= HWDATA_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wmask_q <= '0;
      wtag_q <= '0;
    end else if (st_q == S_WB && BVALID_I) begin
      wmask_q <= '0;
    end else if (st_q == S_IDLE && a_pend_q && a_write_q) begin
      wmask_q <= wmask_q | (8'h01 << a_addr_q[ALIGN_BITS-1:2]);
      wtag_q <= a_addr_q[AW-1:ALIGN_BITS];
    end
  end

  assign ARVALID_O = (st_q == S_RA);
  assign ARADDR_O = {HOST_BASE_I[AW-1:OUT_WIN_BITS] & {(AW-OUT_WIN_BITS){OUT_WIN0_EN}},
                     cv_addr[OUT_WIN_BITS-1:0]};
  assign ARLEN_O = cv_len;
  assign ARSIZE_O = cv_size;
  assign ARBURST_O = cv_burst;
  assign AWVALID_O = (st_q == S_WA);
  assign AWADDR_O = {HOST_BASE_I[AW-1:OUT_WIN_BITS] & {(AW-OUT_WIN_BITS){OUT_WIN0_EN}},
                     wtag_q[OUT_WIN_BITS-1:ALIGN_BITS], {ALIGN_BITS{1'b0}}};
  assign AWLEN_O = LEN_LINE;
  assign AWSIZE_O = SIZE_WORD;
  assign AWBURST_O = BURST_INCR;
  assign WVALID_O = (st_q == S_WD);
  assign WDATA_O = wbuf_q[beat_q];
  assign WSTRB_O = STRB_ALL;
  assign WLAST_O = (beat_q == LAST_IDX);
  assign BREADY_O = (st_q == S_WB);

  logic busy_q;
  logic done_q;
  logic [AW-1:0] moved_q;
  logic [AW-1:0] cyc_q;
  logic burst_end;
  assign burst_end = (st_q == S_RD && sk_valid && sk_data[DW]) || (st_q == S_WB && BVALID_I);

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      busy_q <= 1'b0;
      moved_q <= '0;
      cyc_q <= '0;
      done_q <= 1'b0;
    end else if (DMA_START_I) begin
      busy_q <= 1'b1;
      moved_q <= '0;
      cyc_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (busy_q) begin
        cyc_q <= cyc_q + 32'h1;
        if (burst_end) begin
          moved_q <= moved_q + BYTES_PER_BURST;
          if (moved_q + BYTES_PER_BURST >= XFER_LEN_I) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end
  assign DMA_DONE_O = done_q;
  assign CYCLES_O = cyc_q;

  logic [DIP_W-1:0] dip_m_q;
  logic [DIP_W-1:0] dip_s_q;
  logic btn_m_q;
  logic btn_s_q;
  logic btn_d_q;
  logic irq_q;
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dip_m_q <= '0;
      dip_s_q <= '0;
      btn_m_q <= 1'b0;
      btn_s_q <= 1'b0;
      btn_d_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      dip_m_q <= DIP_I;
      dip_s_q <= dip_m_q;
      btn_m_q <= BTN_I;
      btn_s_q <= btn_m_q;
      btn_d_q <= btn_s_q;
      irq_q <= btn_s_q && !btn_d_q;
    end
  end
  assign HOST_IRQ_O = irq_q;

  logic [LED_W-1:0] led_q;
  logic [DW-1:0] scratch_q;
  logic [DW-1:0] in_rd_q;
  logic in_rv_q;
  logic sram_busy_q;
  logic [AW-1:0] sram_addr_q;
  logic sram_we_q;
  logic [DW-1:0] sram_wd_q;
  logic in_take;
  logic to_sram;
  assign to_sram = IN_BAR_I && (IN_OFFSET_I != SCRATCH_OFF) && WIN1_EN;
  assign IN_READY_O = !sram_busy_q;
  assign in_take = IN_VALID_I && IN_READY_O;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      led_q <= '0;
      scratch_q <= SCRATCH_RST;
      in_rd_q <= '0;
      in_rv_q <= 1'b0;
      sram_busy_q <= 1'b0;
      sram_addr_q <= '0;
      sram_we_q <= 1'b0;
      sram_wd_q <= '0;
    end else begin
      in_rv_q <= 1'b0;
      if (sram_busy_q && SRAM_ACK_I) begin
        sram_busy_q <= 1'b0;
        in_rv_q <= 1'b1;
        in_rd_q <= sram_we_q ? '0 : SRAM_RDATA_I;
      end else if (in_take && to_sram) begin
        sram_busy_q <= 1'b1;
        sram_addr_q <= SRAM_BASE + {{(AW-OFF_W){1'b0}}, IN_OFFSET_I};
        sram_we_q <= IN_WRITE_I;
        sram_wd_q <= IN_WDATA_I;
      end else if (in_take) begin
        in_rv_q <= 1'b1;
        in_rd_q <= '0;
        if (!IN_BAR_I && WIN0_EN) begin
          if (IN_WRITE_I && IN_OFFSET_I == GPIO_OUT_OFF) begin
            led_q <= IN_WDATA_I[LED_W-1:0];
          end
          if (!IN_WRITE_I && IN_OFFSET_I == GPIO_OUT_OFF) begin
            in_rd_q <= {{(DW-LED_W){1'b0}}, led_q};
          end
          if (!IN_WRITE_I && IN_OFFSET_I == GPIO_IN_OFF) begin
            in_rd_q <= {{(DW-DIP_W){1'b0}}, dip_s_q};
          end
        end else if (IN_BAR_I) begin
          if (IN_WRITE_I) begin
            scratch_q <= IN_WDATA_I;
          end else begin
            in_rd_q <= scratch_q;
          end
        end
      end
    end
  end
  assign IN_RVALID_O = in_rv_q;
  assign IN_RDATA_O = in_rd_q;
  assign LED_O = led_q;
  assign SRAM_REQ_O = sram_busy_q;
  assign SRAM_WE_O = sram_we_q;
  assign SRAM_ADDR_O = sram_addr_q;
  assign SRAM_WDATA_O = sram_wd_q;
  assign CFG_BAR_TYPE_O = BAR_MEM32;
  assign CFG_LANES_O = LINK_LANES;
  assign CFG_GEN_O = LINK_GEN2;
  assign CFG_CLK_MHZ_O = CORE_CLK_MHZ;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  AST_AR_INCR: assert property (ARVALID_O |-> ARBURST_O == BURST_INCR)
    else $error("read burst not incrementing");
  AST_AR_LINE: assert property (ARVALID_O |-> ARLEN_O == LEN_LINE && ARSIZE_O == SIZE_WORD
    && ARADDR_O[ALIGN_BITS-1:0] == '0)
    else $error("read burst not one aligned line");
  AST_AR_HOLD: assert property (ARVALID_O && !ARREADY_I |=> ARVALID_O && $stable(ARADDR_O))
    else $error("read address dropped before acceptance");
  AST_AW_LINE: assert property (AWVALID_O |-> AWBURST_O == BURST_INCR && AWLEN_O == LEN_LINE
    && AWADDR_O[ALIGN_BITS-1:0] == '0)
    else $error("write burst shape wrong");
  AST_WLAST: assert property (WVALID_O && WREADY_I && WLAST_O |=> BREADY_O)
    else $error("write burst did not end after last beat");
  AST_WR_FULL: assert property ($rose(AWVALID_O) |-> $past(wmask_q | (8'h01 << a_addr_q[4:2]))
    == MASK_FULL)
    else $error("write burst before buffer full");
  AST_RD_DONE: assert property (st_q == S_RD && sk_valid && sk_data[DW] |=> HREADY_O)
    else $error("read not completed after fill");
  AST_IRQ: assert property (btn_s_q && !btn_d_q |=> HOST_IRQ_O ##1 !HOST_IRQ_O)
    else $error("button press interrupt wrong");
  AST_TIMER: assert property (busy_q && !DMA_START_I |=> cyc_q == $past(cyc_q) + 32'h1)
    else $error("timer failed to count");
  AST_SCRATCH: assert property (in_take && IN_BAR_I && IN_WRITE_I && IN_OFFSET_I == SCRATCH_OFF
    |=> scratch_q == $past(IN_WDATA_I))
    else $error("scratchpad write lost");
  AST_LED: assert property (in_take && !IN_BAR_I && IN_WRITE_I && IN_OFFSET_I == GPIO_OUT_OFF
    |=> LED_O == $past(IN_WDATA_I[LED_W-1:0]))
    else $error("led write lost");

  COV_RD_MISS: cover property (ARVALID_O && ARREADY_I ##[1:40] HREADY_O);
  COV_WR_BURST: cover property (WVALID_O && WREADY_I && WLAST_O);
  COV_IRQ: cover property (HOST_IRQ_O);
  COV_DONE: cover property (DMA_DONE_O);
  COV_MISALIGN: cover property (ARVALID_O && cv_mis);
endmodule

// >>> logic/skid_buf2.sv
module skid_buf2
  import bridge_pkg::*;
#(
  parameter int W = 33
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic in_valid_i, // Word offered.
  output logic in_ready_o, // Room for a word.
  input wire logic [W-1:0] in_data_i, // Word in.
  output logic out_valid_o, // Word available.
  input wire logic out_ready_i, // Drain takes word.
  output logic [W-1:0] out_data_o // Oldest word.
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_q ^ push;
      rp_q <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> logic/wrap_to_incr.sv
module wrap_to_incr
  import bridge_pkg::*;
(
  input wire logic [AW-1:0] addr_i, // Burst start address.
  input wire logic [1:0] burst_i, // Burst type from the requester.
  input wire logic [7:0] len_i, // Beat count minus one.
  input wire logic [2:0] size_i, // Beat size code.
  output logic [AW-1:0] addr_o, // Aligned start address.
  output logic [1:0] burst_o, // Incrementing for a wrap input, else burst_i unchanged.
  output logic [7:0] len_o, // Unchanged beat count.
  output logic [2:0] size_o, // Unchanged beat size.
  output logic misalign_o // Start not on a line boundary.
);
  always_comb begin
    addr_o = {addr_i[AW-1:ALIGN_BITS], {ALIGN_BITS{1'b0}}};
    burst_o = (burst_i == BURST_WRAP) ? BURST_INCR : burst_i;
    len_o = len_i;
    size_o = size_i;
    misalign_o = |addr_i[ALIGN_BITS-1:0];
  end
endmodule
